// ==== rtl/p3pf_port.sv ====
// port 3 pin function control: apb registers, pin sampling and registered pad drive
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module p3pf_port
    import p3pf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pin_pull_up,
    output logic [7:0] pin_pull_down,
    input wire logic [7:0][2:0] periph_out,
    output logic [7:0] pin_level,
    output logic [7:0] external_interrupt_input,
    output logic fifo_serial_data_in,
    output logic fifo_serial_clock,
    output logic fifo_serial_chip_select
);

    logic [7:0] port_data_bits;
    logic [7:0] port_direction_bits;
    logic [15:0] drive_type_bits;
    logic [15:0] port3_function_select;
    logic [7:0] next_port_data_bits;
    logic [7:0] next_port_direction_bits;
    logic [15:0] next_drive_type_bits;
    logic [15:0] next_port3_function_select;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [7:0] next_pin_level;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe_n;
    logic [7:0] next_pin_pull_up;
    logic [7:0] next_pin_pull_down;
    logic setup_phase;
    logic access_phase;
    logic addr_hit;
    logic [7:0] drive_type_low_bits;
    logic [7:0] drive_type_high_bits;
    logic [7:0] function_select_low_byte;
    logic [7:0] function_select_high_byte;
    logic [7:0] prohibited;
    logic [7:0] data_view;
    p3pf_drive_t cell_drive [P3PF_PINS];

    // apb phases; no wait states, so pready is a constant handshake
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign pready = 1'b1;

    // byte views of the 16-bit registers
    assign drive_type_low_bits = drive_type_bits[P3PF_LO_LSB +: 8];
    assign drive_type_high_bits = drive_type_bits[P3PF_HI_LSB +: 8];
    assign function_select_low_byte = port3_function_select[P3PF_LO_LSB +: 8];
    assign function_select_high_byte = port3_function_select[P3PF_HI_LSB +: 8];

    // address decode; misaligned or unknown addresses answer with pslverr
    always_comb begin
        case (paddr)
            P3PF_DATA_OFS: addr_hit = 1'b1;
            P3PF_DIR_OFS: addr_hit = 1'b1;
            P3PF_CON_OFS: addr_hit = 1'b1;
            P3PF_FSEL_OFS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    // data reads mix written values for outputs with pin levels for inputs
    assign data_view = (port_direction_bits & pin_level) |
        (~port_direction_bits & port_data_bits);

    // register writes, taken at the access edge under byte strobes
    always_comb begin
        next_port_data_bits = port_data_bits;
        next_port_direction_bits = port_direction_bits;
        next_drive_type_bits = drive_type_bits;
        next_port3_function_select = port3_function_select;
        if (access_phase && pwrite) begin
            case (paddr)
                P3PF_DATA_OFS: begin
                    if (pstrb[P3PF_STRB_LO]) begin
                        next_port_data_bits = pwdata[7:0];
                    end
                end
                P3PF_DIR_OFS: begin
                    if (pstrb[P3PF_STRB_LO]) begin
                        next_port_direction_bits = pwdata[7:0];
                    end
                end
                P3PF_CON_OFS: begin
                    if (pstrb[P3PF_STRB_LO]) begin
                        next_drive_type_bits[P3PF_LO_LSB +: 8] = pwdata[7:0];
                    end
                    if (pstrb[P3PF_STRB_HI]) begin
                        next_drive_type_bits[P3PF_HI_LSB +: 8] = pwdata[15:8];
                    end
                end
                P3PF_FSEL_OFS: begin
                    if (pstrb[P3PF_STRB_LO]) begin
                        next_port3_function_select[P3PF_LO_LSB +: 8] = pwdata[7:0];
                    end
                    if (pstrb[P3PF_STRB_HI]) begin
                        next_port3_function_select[P3PF_HI_LSB +: 8] = pwdata[15:8];
                    end
                end
                default: begin
                    next_port_data_bits = port_data_bits;
                end
            endcase
        end
    end

    // registers come up as high-z gpio outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_bits <= P3PF_DATA_RST;
            port_direction_bits <= P3PF_DIR_RST;
            drive_type_bits <= P3PF_CON_RST;
            port3_function_select <= P3PF_FSEL_RST;
        end else begin
            port_data_bits <= next_port_data_bits;
            port_direction_bits <= next_port_direction_bits;
            drive_type_bits <= next_drive_type_bits;
            port3_function_select <= next_port3_function_select;
        end
    end

    // read data and error are captured in setup so they stand from a flop in access
    always_comb begin
        next_prdata = P3PF_RDATA_ZERO;
        next_pslverr = 1'b0;
        if (setup_phase) begin
            next_pslverr = ~addr_hit;
            if (!pwrite) begin
                case (paddr)
                    P3PF_DATA_OFS: next_prdata[7:0] = data_view;
                    P3PF_DIR_OFS: next_prdata[7:0] = port_direction_bits;
                    P3PF_CON_OFS: next_prdata[15:0] = drive_type_bits;
                    P3PF_FSEL_OFS: next_prdata[15:0] = port3_function_select;
                    default: next_prdata = P3PF_RDATA_ZERO;
                endcase
            end
        end
    end

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= P3PF_RDATA_ZERO;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // one cell per pin; code joins high byte bit and low byte bit
    genvar g;
    generate
        for (g = 0; g < P3PF_PINS; g++) begin : g_pin
            logic [1:0] code;
            assign code = {function_select_high_byte[g], function_select_low_byte[g]};
            assign prohibited[g] =
                (P3PF_PROHIB_SECOND[g] && code == P3PF_FN_SECOND) ||
                (P3PF_PROHIB_THIRD[g] && code == P3PF_FN_THIRD);
            p3pf_pin_cell u_cell (
                .direction(port_direction_bits[g]),
                .drive_type({drive_type_high_bits[g], drive_type_low_bits[g]}),
                .func_code(code),
                .prohibited(prohibited[g]),
                .data_bit(port_data_bits[g]),
                .periph_bits(periph_out[g]),
                .drive(cell_drive[g])
            );
            assign next_pin_out[g] = cell_drive[g].out;
            assign next_pin_oe_n[g] = cell_drive[g].oe_n;
            assign next_pin_pull_up[g] = cell_drive[g].pull_up;
            assign next_pin_pull_down[g] = cell_drive[g].pull_down;
        end
    endgenerate

    // pins are synchronous; one flop of sampling feeds reads and peripherals
    assign next_pin_level = pin_in;

    // pad drive is registered, so settings reach the pins one cycle after a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level <= 8'h00;
            pin_out <= 8'h00;
            pin_oe_n <= 8'hFF;
            pin_pull_up <= 8'h00;
            pin_pull_down <= 8'h00;
        end else begin
            pin_level <= next_pin_level;
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            pin_pull_up <= next_pin_pull_up;
            pin_pull_down <= next_pin_pull_down;
        end
    end

    // interrupt inputs pass only for gpio pins in input mode
    assign external_interrupt_input = pin_level & port_direction_bits &
        ~function_select_low_byte & ~function_select_high_byte;

    // fifo serial inputs see their pin only while the third code is selected
    assign fifo_serial_data_in = pin_level[P3PF_PIN_SER_DATA] &
        ({function_select_high_byte[P3PF_PIN_SER_DATA],
          function_select_low_byte[P3PF_PIN_SER_DATA]} == P3PF_FN_THIRD);
    assign fifo_serial_clock = pin_level[P3PF_PIN_SER_CLK] &
        ({function_select_high_byte[P3PF_PIN_SER_CLK],
          function_select_low_byte[P3PF_PIN_SER_CLK]} == P3PF_FN_THIRD);
    assign fifo_serial_chip_select = pin_level[P3PF_PIN_SER_CS] &
        ({function_select_high_byte[P3PF_PIN_SER_CS],
          function_select_low_byte[P3PF_PIN_SER_CS]} == P3PF_FN_THIRD);

    // helper vectors for the checks below
    logic [7:0] is_out_gpio;
    logic [7:0] hiz_gpio;
    logic [7:0] cmos_gpio;
    logic [7:0] prohib_low;
    logic [7:0] prohib_float;
    logic [7:0] in_pull_up;
    logic [1:0] pin5_code;
    assign is_out_gpio = ~port_direction_bits & ~function_select_low_byte &
        ~function_select_high_byte;
    assign hiz_gpio = is_out_gpio & ~drive_type_low_bits & ~drive_type_high_bits;
    assign cmos_gpio = is_out_gpio & drive_type_low_bits & drive_type_high_bits;
    assign prohib_low = prohibited & ~port_direction_bits & drive_type_high_bits;
    assign prohib_float = prohibited & ~port_direction_bits & ~drive_type_high_bits;
    assign in_pull_up = port_direction_bits & ~drive_type_low_bits & drive_type_high_bits;
    assign pin5_code = {function_select_high_byte[P3PF_PIN_SER_DATA],
        function_select_low_byte[P3PF_PIN_SER_DATA]};

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    gpio_hiz_float_a: assert property (1'b1 |=> (($past(hiz_gpio) & ~pin_oe_n) == 8'h00))
        else $error("high-z gpio output pin is driven");
    cmos_follows_data_a: assert property (1'b1 |=>
        ((($past(cmos_gpio) & (pin_out ^ $past(port_data_bits))) == 8'h00) &&
         (($past(cmos_gpio) & pin_oe_n) == 8'h00)))
        else $error("cmos gpio pin does not follow data bit");
    prohib_low_a: assert property (1'b1 |=>
        ((($past(prohib_low) & (pin_oe_n | pin_out)) == 8'h00)))
        else $error("prohibited pin not held low");
    prohib_float_a: assert property (1'b1 |=> (($past(prohib_float) & ~pin_oe_n) == 8'h00))
        else $error("prohibited pin not floating");
    input_undriven_a: assert property (1'b1 |=>
        (($past(port_direction_bits) & ~pin_oe_n) == 8'h00))
        else $error("input pin is driven");
    pull_up_sel_a: assert property (1'b1 |=>
        (pin_pull_up == $past(in_pull_up)) && ((pin_pull_up & pin_pull_down) == 8'h00))
        else $error("pull selection wrong");
    read_level_a: assert property ((setup_phase && !pwrite && paddr == P3PF_DATA_OFS &&
        port_direction_bits == 8'hFF) |=> (prdata[7:0] == $past(pin_level)))
        else $error("data read does not show pin levels");
    periph_route_a: assert property ((!port_direction_bits[P3PF_PIN_SER_DATA] &&
        pin5_code == P3PF_FN_FOURTH && drive_type_low_bits[P3PF_PIN_SER_DATA]) |=>
        (pin_out[P3PF_PIN_SER_DATA] == $past(periph_out[P3PF_PIN_SER_DATA][2]) &&
         !pin_oe_n[P3PF_PIN_SER_DATA]))
        else $error("pin 5 does not carry fifo uart output");
    fsel_write_a: assert property ((access_phase && pwrite && paddr == P3PF_FSEL_OFS &&
        pstrb[1:0] == 2'b11) |=> (port3_function_select == $past(pwdata[15:0])))
        else $error("function select write lost");
    apb_error_a: assert property ((setup_phase && !addr_hit) |=> (pslverr && penable))
        else $error("unmapped address not refused");

    fsel_write_c: cover property (access_phase && pwrite && paddr == P3PF_FSEL_OFS);
    data_read_c: cover property (access_phase && !pwrite && paddr == P3PF_DATA_OFS);
    prohib_low_c: cover property (prohib_low != 8'h00);
    periph_pin_c: cover property (pin5_code == P3PF_FN_FOURTH && !port_direction_bits[5]);

endmodule
`default_nettype wire

// ==== inc/p3pf_pkg.sv ====
// package: register map, field codes and pin drive carrier for the port 3 function block
package p3pf_pkg;

    localparam int P3PF_PINS = 8;

    // apb byte addresses, one aligned word each
    localparam logic [11:0] P3PF_DATA_OFS = 12'h000;
    localparam logic [11:0] P3PF_DIR_OFS = 12'h004;
    localparam logic [11:0] P3PF_CON_OFS = 12'h008;
    localparam logic [11:0] P3PF_FSEL_OFS = 12'h00C;

    // reset values: every pin a high-impedance gpio output
    localparam logic [7:0] P3PF_DATA_RST = 8'h00;
    localparam logic [7:0] P3PF_DIR_RST = 8'h00;
    localparam logic [15:0] P3PF_CON_RST = 16'h0000;
    localparam logic [15:0] P3PF_FSEL_RST = 16'h0000;
    localparam logic [31:0] P3PF_RDATA_ZERO = 32'h0000_0000;

    // low byte / high byte lanes of the 16-bit registers
    localparam int P3PF_LO_LSB = 0;
    localparam int P3PF_HI_LSB = 8;
    localparam int P3PF_STRB_LO = 0;
    localparam int P3PF_STRB_HI = 1;

    // direction bit values
    localparam logic P3PF_DIR_OUT = 1'b0;
    localparam logic P3PF_DIR_IN = 1'b1;

    // drive type codes {high bit, low bit}
    localparam logic [1:0] P3PF_CON_00 = 2'b00;
    localparam logic [1:0] P3PF_CON_01 = 2'b01;
    localparam logic [1:0] P3PF_CON_10 = 2'b10;
    localparam logic [1:0] P3PF_CON_11 = 2'b11;

    // function codes {high bit, low bit}
    localparam logic [1:0] P3PF_FN_GPIO = 2'b00;
    localparam logic [1:0] P3PF_FN_SECOND = 2'b01;
    localparam logic [1:0] P3PF_FN_THIRD = 2'b10;
    localparam logic [1:0] P3PF_FN_FOURTH = 2'b11;

    // pins whose second or third code is prohibited
    localparam logic [7:0] P3PF_PROHIB_SECOND = 8'hC4;
    localparam logic [7:0] P3PF_PROHIB_THIRD = 8'h08;

    // pins carrying the fifo serial inputs
    localparam int P3PF_PIN_SER_DATA = 5;
    localparam int P3PF_PIN_SER_CLK = 6;
    localparam int P3PF_PIN_SER_CS = 7;

    // state of one pin pad
    typedef struct packed {
        logic out;
        logic oe_n;
        logic pull_up;
        logic pull_down;
    } p3pf_drive_t;

endpackage

// ==== rtl/p3pf_pin_cell.sv ====
// one port pin: drive type, function routing and prohibited-code forcing
`timescale 1ns/10ps
`default_nettype none
module p3pf_pin_cell
    import p3pf_pkg::*;
(
    input wire logic direction,
    input wire logic [1:0] drive_type,
    input wire logic [1:0] func_code,
    input wire logic prohibited,
    input wire logic data_bit,
    input wire logic [2:0] periph_bits,
    output var p3pf_drive_t drive
);

    logic periph_val;

    // pick the peripheral source for codes 01, 10, 11
    always_comb begin
        case (func_code)
            P3PF_FN_SECOND: periph_val = periph_bits[0];
            P3PF_FN_THIRD: periph_val = periph_bits[1];
            P3PF_FN_FOURTH: periph_val = periph_bits[2];
            default: periph_val = 1'b0;
        endcase
    end

    // pad control; oe_n low means the pad is driven
    always_comb begin
        drive = '{out: 1'b0, oe_n: 1'b1, pull_up: 1'b0, pull_down: 1'b0};
        if (direction == P3PF_DIR_IN) begin
            // pulls only in input mode, never fighting a driver
            drive.pull_down = (drive_type == P3PF_CON_01);
            drive.pull_up = (drive_type == P3PF_CON_10);
        end else if (prohibited) begin
            // data bit ignored: float or hard low
            drive.oe_n = ~drive_type[1];
            drive.out = 1'b0;
        end else if (func_code == P3PF_FN_GPIO) begin
            case (drive_type)
                P3PF_CON_01: begin
                    drive.out = 1'b1;
                    drive.oe_n = ~data_bit;
                end
                P3PF_CON_10: begin
                    drive.out = 1'b0;
                    drive.oe_n = data_bit;
                end
                P3PF_CON_11: begin
                    drive.out = data_bit;
                    drive.oe_n = 1'b0;
                end
                default: begin
                    drive.oe_n = 1'b1;
                end
            endcase
        end else begin
            // peripherals get only n open drain or cmos
            if (drive_type[0]) begin
                drive.out = periph_val;
                drive.oe_n = 1'b0;
            end else begin
                drive.out = 1'b0;
                drive.oe_n = periph_val;
            end
        end
    end

endmodule
`default_nettype wire

// ==== verification/p3pf_pad_model.sv ====
// pad model: resolves each port pin from the block's drive, outside drivers and pulls
`timescale 1ns/10ps
`default_nettype none
module p3pf_pad_model
    import p3pf_pkg::*;
(
    input wire logic pclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pull_up,
    input wire logic [7:0] pin_pull_down,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] float_pat = 8'h5A;

    // an undriven unpulled pad flips every cycle so no lucky level can pass
    always @(posedge pclk) begin
        float_pat <= ~float_pat;
    end

    // block drive wins, then outside driver, then pull, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_n[i] == 1'b0) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pull_up[i]) begin
                pin_in[i] = 1'b1;
            end else if (pin_pull_down[i]) begin
                pin_in[i] = 1'b0;
            end else begin
                pin_in[i] = float_pat[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// testbench: apb register access and pin behaviour of the port 3 function block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import p3pf_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_down, pin_level, eii;
    logic [7:0][2:0] periph_out;
    logic fs_data, fs_clk, fs_cs, er;
    logic [7:0] ext_en, ext_val, sh_data, sh_dir;
    logic [15:0] sh_con, sh_fsel;
    int err_total, num_checks, rnd;

    p3pf_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
        .periph_out(periph_out), .pin_level(pin_level), .external_interrupt_input(eii),
        .fifo_serial_data_in(fs_data), .fifo_serial_clock(fs_clk),
        .fifo_serial_chip_select(fs_cs));
    p3pf_pad_model pads (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    // 50 mhz clock
    always #10 pclk = ~pclk;

    task automatic finish_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1) begin
            err_total++;
            $display("BAD %0t apb answer missing", $time);
            finish_test();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // level the pad shows when the block does not drive it
    function automatic logic pad_lvl(input int i);
        return ext_en[i] ? ext_val[i] : pin_pull_up[i];
    endfunction

    // compare every pin against what the shadow registers call for
    task automatic check_pins();
        logic [1:0] fn, cc, epull;
        logic proh, eoe, eo, v, fs;
        logic [7:0] erd;
        @(negedge pclk);
        for (int i = 0; i < 8; i++) begin
            fn = {sh_fsel[P3PF_HI_LSB + i], sh_fsel[i]};
            cc = {sh_con[P3PF_HI_LSB + i], sh_con[i]};
            proh = (fn == P3PF_FN_SECOND && P3PF_PROHIB_SECOND[i]) ||
                   (fn == P3PF_FN_THIRD && P3PF_PROHIB_THIRD[i]);
            eo = 1'b0;
            eoe = 1'b1;
            if (sh_dir[i] == P3PF_DIR_IN) begin
                eoe = 1'b1;
            end else if (proh) begin
                eoe = ~cc[1];
            end else if (fn == P3PF_FN_GPIO) begin
                eo = (cc == P3PF_CON_01) | (sh_data[i] & cc == P3PF_CON_11);
                eoe = (cc == P3PF_CON_00) | (cc == P3PF_CON_01 & ~sh_data[i]) |
                      (cc == P3PF_CON_10 & sh_data[i]);
            end else begin
                v = periph_out[i][fn - 2'd1];
                eo = cc[0] & v;
                eoe = ~cc[0] & v;
            end
            chk(32'(pin_oe_n[i]), 32'(eoe));
            if (eoe == 1'b0) begin
                chk(32'(pin_out[i]), 32'(eo));
            end
            // code 11 in input mode floats, and outputs never pull
            epull = (sh_dir[i] == P3PF_DIR_IN && cc != P3PF_CON_11) ? cc : P3PF_CON_00;
            chk(32'({pin_pull_up[i], pin_pull_down[i]}), 32'(epull));
            if (sh_dir[i] == P3PF_DIR_IN) begin
                chk(32'(pin_level[i]), 32'(pad_lvl(i)));
            end
            chk(32'(eii[i]), 32'(sh_dir[i] & (fn == P3PF_FN_GPIO) & pad_lvl(i)));
            fs = (i == 5) ? fs_data : ((i == 6) ? fs_clk : fs_cs);
            if (i >= P3PF_PIN_SER_DATA && sh_dir[i] == P3PF_DIR_IN) begin
                chk(32'(fs), 32'((fn == P3PF_FN_THIRD) & pad_lvl(i)));
            end
            erd[i] = sh_dir[i] ? pad_lvl(i) : sh_data[i];
        end
        apb(1'b0, P3PF_DATA_OFS, 32'h0, 4'h0, rd, er);
        chk(rd, 32'(erd));
    endtask

    // program all four registers, let the pads settle, then check
    task automatic setup(input logic [7:0] d, input logic [7:0] di, input logic [15:0] c,
                         input logic [15:0] f);
        sh_data = d;
        sh_dir = di;
        sh_con = c;
        sh_fsel = f;
        apb(1'b1, P3PF_DATA_OFS, 32'(d), 4'h1, rd, er);
        apb(1'b1, P3PF_DIR_OFS, 32'(di), 4'h1, rd, er);
        apb(1'b1, P3PF_CON_OFS, 32'(c), 4'h3, rd, er);
        apb(1'b1, P3PF_FSEL_OFS, 32'(f), 4'h3, rd, er);
        apb(1'b0, P3PF_FSEL_OFS, 32'h0, 4'h0, rd, er);
        chk(rd, 32'(f));
        repeat (3) @(posedge pclk);
        check_pins();
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        periph_out = '0;
        ext_en = 8'hFF;
        ext_val = 8'h00;
        err_total = 0;
        num_checks = 0;
        rnd = $urandom(53);
        repeat (4) @(posedge pclk);
        chk(32'(pin_oe_n), 32'h0000_00FF);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 12'(a), 32'h0, 4'h0, rd, er);
            chk(rd, 32'h0000_0000);
        end
        // unmapped address: error flag, nothing read
        apb(1'b0, 12'h010, 32'h0, 4'h0, rd, er);
        chk({rd[30:0], er}, 32'h0000_0001);
        // low byte alone may be written
        apb(1'b1, P3PF_FSEL_OFS, 32'h0000_A5C3, 4'h1, rd, er);
        apb(1'b0, P3PF_FSEL_OFS, 32'h0, 4'h0, rd, er);
        chk(rd, 32'h0000_00C3);
        setup(8'h00, 8'h00, 16'h0000, 16'h0000);
        // every drive type under the prohibited codes, both data levels
        for (int c = 0; c < 8; c++) begin
            setup({8{c[2]}}, 8'h00, {{8{c[1]}}, {8{c[0]}}}, 16'h08C4);
        end
        for (int k = 0; k < 40; k++) begin
            ext_val <= 8'($urandom);
            periph_out <= 24'($urandom);
            setup(8'($urandom), 8'($urandom), 16'($urandom), 16'($urandom));
        end
        // a reset in mid-run clears every register and floats every pin
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(pin_oe_n), 32'h0000_00FF);
        chk(32'({pin_pull_up, pin_pull_down, pin_out}), 32'h0000_0000);
        presetn <= 1'b1;
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b0, 12'(a), 32'h0, 4'h0, rd, er);
            chk(rd, 32'h0000_0000);
        end
        // pulls alone decide input levels with nothing driving
        ext_en <= 8'h00;
        setup(8'h00, 8'hFF, 16'hF00F, 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
